/* spi_pkg.sv */
package spi_pkg;

    // Legacy interrupt line numbering.
    localparam int LINE_A = 0;
    localparam int NUM_LINES = 4;

    // Register word offsets (byte addresses).
    localparam logic [5:0] OFS_MSI_EN   = 6'h00;
    localparam logic [5:0] OFS_LEG_DIS  = 6'h04;
    localparam logic [5:0] OFS_BW_EN    = 6'h08;
    localparam logic [5:0] OFS_DL_UP    = 6'h0C;
    localparam logic [5:0] OFS_IRQ_STS  = 6'h10;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h14;
    localparam logic [5:0] OFS_UP_STATE = 6'h18;
    localparam logic [5:0] OFS_MSI_CNT  = 6'h1C;

    // Reset values.
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] RST_ONES = 32'hFFFF_FFFF;

    // Interrupt status bit positions.
    localparam int STS_ASSERT   = 0;
    localparam int STS_DEASSERT = 1;
    localparam int STS_MSI      = 2;

    // Message from a downstream port toward the switch core.
    typedef struct packed {
        logic       msi;
        logic       assert_inta;
        logic       deassert_inta;
    } spi_req_type;

    // Message from the upstream port to the root.
    typedef struct packed {
        logic       valid;
        logic       assert_n_deassert;
        logic [1:0] line;
    } spi_msg_type;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b10
    } spi_bus_type;

endpackage

/* spi_dsport.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_dsport (
    input  wire logic                ref_clk,
    input  wire logic                rst_sync_b,
    input  wire logic                hot_plug_irq,
    input  wire logic [1:0]          bw_status,
    input  wire logic [1:0]          bw_notify_en,
    input  wire logic                msi_enable,
    input  wire logic                legacy_irq_disable,
    input  wire logic                port_down,
    output spi_pkg::spi_req_type     req,
    output var logic                 wire_inta
);

    logic cond;
    logic cond_q;
    logic rise;
    logic fall;
    logic legacy_ok;
    logic next_wire;

    // Only hot-plug and enabled bandwidth bits count; masked bits drop out.
    assign cond = hot_plug_irq | (|(bw_status & bw_notify_en)); // RQ6 RQ4
    assign rise = cond & ~cond_q;
    assign fall = ~cond & cond_q;
    assign legacy_ok = ~msi_enable & ~legacy_irq_disable;
    // A downed port drops its virtual wire at once.
    assign next_wire = port_down ? 1'b0 : (legacy_ok ? cond : wire_inta); // RQ14

    // Edge detection and the INTA virtual wire, the only line used.
    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cond_q <= 1'b0;
            wire_inta <= 1'b0;
            req <= '0;
        end else begin
            cond_q <= cond;
            wire_inta <= next_wire; // RQ7
            req.msi <= rise & msi_enable; // RQ1 RQ5
            req.assert_inta <= rise & legacy_ok; // RQ2
            req.deassert_inta <= fall & legacy_ok; // RQ3
        end
    end

endmodule
`default_nettype wire

/* spi_top.sv */
// The implementer's own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// How it works
// RQ1: Unmasked rise with MSI enabled emits MSI regardless of legacy disable.
// RQ2: MSI off and legacy enabled: rise requests INTA assert; disabled: nothing.
// RQ3: Fall requests INTA deassert only with MSI off and legacy enabled.
// RQ4: Condition ends when all causing unmasked bits are masked or cleared.
// RQ5: Every port MSI is forwarded toward the upstream port.
// RQ6: Sources are hot-plug and enabled bandwidth notification status bits.
// RQ7: Ports send their own legacy interrupts on INTA only.
// RQ8: Four aggregated line states, A to D, kept per partition.
// RQ9: Upstream sends Assert_INTx when an aggregate line rises.
// RQ10: Upstream sends Deassert_INTx when an aggregate line falls.
// RQ11: Downstream bridges pass lines through without remapping.
// RQ12: Upstream remaps line k of device N to (k + N mod 4) mod 4.
// RQ13: Remapped input ORs external and port-generated interrupts per line.
// RQ14: A down or removed port negates its wires and updates the aggregate.
// RQ15: Software must point MSI addresses at the upstream port.
// RQ16: Software keeps MSI addresses outside the multicast aperture.
// RQ17: Aggregate line is the OR of remapped wires and upstream's own.
// RQ18: Aggregation and messages are independent per partition.
module spi_top #(
    parameter int NPORT = 4
) (
    input  wire logic                   ref_clk,
    input  wire logic                   rst_b,
    input  wire logic [NPORT-1:0]       hot_plug_irq,
    input  wire logic [NPORT*2-1:0]     bw_status,
    input  wire logic [NPORT*4-1:0]     ext_intx,
    input  wire logic [NPORT*2-1:0]     dev_num,
    input  wire logic [3:0]             up_own_intx,
    input  wire logic [5:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output var logic [31:0]             avs_readdata,
    output var logic                    avs_waitrequest,
    output spi_pkg::spi_msg_type        root_msg,
    output var logic [NPORT-1:0]        msi_fwd,
    output var logic                    irq
);

    logic               rst_s1;
    logic               rst_sync_b;
    logic [NPORT-1:0]   msi_enable;
    logic [NPORT-1:0]   legacy_irq_disable;
    logic [NPORT*2-1:0] bw_notify_en;
    logic [NPORT-1:0]   port_up;
    logic [31:0]        irq_status;
    logic [31:0]        irq_mask;
    logic [15:0]        msi_count;
    logic [3:0]         agg;
    logic [3:0]         agg_q;
    logic [3:0]         pend_assert;
    logic [3:0]         pend_deassert;
    logic [NPORT-1:0]   port_wire;
    logic [NPORT-1:0]   port_msi;
    logic [NPORT-1:0]   port_areq;
    logic [NPORT-1:0]   port_dreq;
    spi_pkg::spi_bus_type bus_state;

    // Reset is released through two flops so all logic leaves it together.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1 <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_sync_b <= rst_s1;
        end
    end

    // One downstream port each; the bridge itself does no remapping.
    genvar gp;
    generate
        for (gp = 0; gp < NPORT; gp++) begin : g_port
            spi_pkg::spi_req_type r;
            spi_dsport u_port (
                .ref_clk            (ref_clk),
                .rst_sync_b         (rst_sync_b),
                .hot_plug_irq       (hot_plug_irq[gp]),
                .bw_status          (bw_status[gp*2 +: 2]),
                .bw_notify_en       (bw_notify_en[gp*2 +: 2]),
                .msi_enable         (msi_enable[gp]),
                .legacy_irq_disable (legacy_irq_disable[gp]),
                .port_down          (~port_up[gp]),
                .req                (r),
                .wire_inta          (port_wire[gp])
            ); // RQ11
            assign port_msi[gp]  = r.msi;
            assign port_areq[gp] = r.assert_inta;
            assign port_dreq[gp] = r.deassert_inta;
        end
    endgenerate

    // Rotate a downstream line by the device number.
    function automatic logic [3:0] rotate_lines(input logic [3:0] v,
                                                input logic [1:0] n);
        logic [3:0] o;
        o = '0;
        for (int k = 0; k < spi_pkg::NUM_LINES; k++) begin
            o[2'(k + int'(n))] = v[k]; // RQ12
        end
        return o;
    endfunction

    // Aggregate: OR of remapped wires and up_own_intx; a down port contributes nothing.
    always_comb begin
        agg = up_own_intx; // RQ17
        for (int p = 0; p < NPORT; p++) begin
            agg = agg | rotate_lines(
                (ext_intx[p*4 +: 4] & {4{port_up[p]}}) |
                {3'h0, port_wire[p]}, dev_num[p*2 +: 2]); // RQ13 RQ14
        end
    end

    // Edge of each of the four aggregate states.
    logic [3:0] agg_rise;
    logic [3:0] agg_fall;
    assign agg_rise = agg & ~agg_q; // RQ9
    assign agg_fall = ~agg & agg_q; // RQ10

    // Pick the lowest pending line; asserts first, one message a cycle.
    logic [3:0] pa_all;
    logic [3:0] pd_all;
    logic       send_a;
    logic       send_d;
    logic [1:0] sel_line;
    logic [3:0] sel_onehot;
    // An edge that meets an unsent opposite message drops both, so the root
    // never sees a deassert for a line that it still holds negated.
    assign pa_all = (pend_assert & ~agg_fall) | (agg_rise & ~pend_deassert);
    assign pd_all = (pend_deassert & ~agg_rise) | (agg_fall & ~pend_assert);
    assign send_a = |pa_all;
    assign send_d = ~send_a & (|pd_all);
    always_comb begin
        logic [3:0] src;
        src = send_a ? pa_all : pd_all;
        sel_line = 2'h0;
        for (int k = spi_pkg::NUM_LINES - 1; k >= 0; k--) begin
            if (src[k]) begin
                sel_line = 2'(k);
            end
        end
    end
    assign sel_onehot = (send_a | send_d) ? (4'h1 << sel_line) : 4'h0;

    // Message queue per line; a later edge cancels an unsent opposite one.
    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            agg_q <= 4'h0;
            pend_assert <= 4'h0;
            pend_deassert <= 4'h0;
            root_msg <= '0;
        end else begin
            agg_q <= agg; // RQ8 RQ18
            pend_assert <= pa_all & ~(send_a ? sel_onehot : 4'h0);
            pend_deassert <= pd_all & ~(send_d ? sel_onehot : 4'h0);
            root_msg.valid <= send_a | send_d; // RQ9 RQ10
            root_msg.assert_n_deassert <= send_a;
            root_msg.line <= sel_line;
        end
    end

    // Register bus decode; a write lands on the edge that ends its answer.
    logic        acc;
    logic        wr_hit;
    logic [31:0] bmask;
    logic [31:0] rd_mux;
    logic [31:0] ev;
    assign acc = (bus_state == spi_pkg::ST_WRITE) & ~avs_waitrequest;
    assign wr_hit = avs_write & acc;
    assign bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign ev = {29'h0, |port_msi, |port_dreq, |port_areq};
    assign rd_mux =
        (avs_address == spi_pkg::OFS_MSI_EN)   ? 32'(msi_enable) :
        (avs_address == spi_pkg::OFS_LEG_DIS)  ? 32'(legacy_irq_disable) :
        (avs_address == spi_pkg::OFS_BW_EN)    ? 32'(bw_notify_en) :
        (avs_address == spi_pkg::OFS_DL_UP)    ? 32'(port_up) :
        (avs_address == spi_pkg::OFS_IRQ_STS)  ? irq_status :
        (avs_address == spi_pkg::OFS_IRQ_MASK) ? irq_mask :
        (avs_address == spi_pkg::OFS_UP_STATE) ? {28'h0, agg_q} :
        (avs_address == spi_pkg::OFS_MSI_CNT)  ? {16'h0, msi_count} :
        spi_pkg::RST_ZERO;

    // Merge a write into a register under the byte enables.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [31:0] m);
        return (old & ~m) | (wd & m);
    endfunction

    // Control registers; one wait cycle per access keeps timing simple.
    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            bus_state <= spi_pkg::ST_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= spi_pkg::RST_ZERO;
            msi_enable <= '0;
            legacy_irq_disable <= '0;
            bw_notify_en <= '0;
            port_up <= '0;
            irq_mask <= spi_pkg::RST_ZERO;
        end else begin
            avs_waitrequest <= 1'b1;
            case (bus_state)
                spi_pkg::ST_IDLE: begin
                    if (avs_read | avs_write) begin
                        bus_state <= avs_write ? spi_pkg::ST_WRITE
                                               : spi_pkg::ST_READ;
                        avs_waitrequest <= 1'b0;
                        avs_readdata <= avs_read ? rd_mux : 32'h0;
                    end
                end
                spi_pkg::ST_READ, spi_pkg::ST_WRITE: begin
                    bus_state <= spi_pkg::ST_IDLE;
                end
                default: begin
                    bus_state <= spi_pkg::ST_IDLE;
                end
            endcase
            if (wr_hit) begin
                case (avs_address)
                    spi_pkg::OFS_MSI_EN: begin
                        msi_enable <= NPORT'(merge(32'(msi_enable),
                                      avs_writedata, bmask));
                    end
                    spi_pkg::OFS_LEG_DIS: begin
                        legacy_irq_disable <= NPORT'(merge(
                            32'(legacy_irq_disable), avs_writedata, bmask));
                    end
                    spi_pkg::OFS_BW_EN: begin
                        bw_notify_en <= (NPORT*2)'(merge(32'(bw_notify_en),
                                        avs_writedata, bmask));
                    end
                    spi_pkg::OFS_DL_UP: begin
                        port_up <= NPORT'(merge(32'(port_up),
                                   avs_writedata, bmask));
                    end
                    spi_pkg::OFS_IRQ_MASK: begin
                        irq_mask <= merge(irq_mask, avs_writedata, bmask);
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Sticky status: a new event in the clear cycle wins over the clear.
    logic [31:0] clr;
    assign clr = (wr_hit && avs_address == spi_pkg::OFS_IRQ_STS)
                 ? (avs_writedata & bmask) : 32'h0;
    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            irq_status <= spi_pkg::RST_ZERO;
            msi_count <= 16'h0000;
            msi_fwd <= '0;
            irq <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~clr) | ev;
            msi_count <= msi_count + 16'(|port_msi);
            msi_fwd <= port_msi; // RQ5
            irq <= |(irq_status & irq_mask);
        end
    end

endmodule
`default_nettype wire

/* spi_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_top_sva #(
    parameter int NPORT = 4
) (
    input wire logic                 ref_clk,
    input wire logic                 rst_b,
    input wire logic [NPORT-1:0]     hot_plug_irq,
    input wire logic [NPORT*2-1:0]   bw_status,
    input wire logic [3:0]           up_own_intx,
    input wire logic [5:0]           avs_address,
    input wire logic                 avs_read,
    input wire logic                 avs_write,
    input wire logic [31:0]          avs_readdata,
    input wire logic                 avs_waitrequest,
    input wire spi_pkg::spi_msg_type root_msg,
    input wire logic [NPORT-1:0]     msi_fwd
);
    // Last message sent per line, so each line must alternate.
    logic [3:0] seen;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            seen <= 4'h0;
        end else if (root_msg.valid) begin
            seen[root_msg.line] <= root_msg.assert_n_deassert;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Bus answers come one cycle after the request and stand one cycle.
    a_wait_one: assert property (
        $rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("bus answer not one cycle after request");
    a_answer_short: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("bus answer stood more than one cycle");
    a_no_unasked: assert property (
        !avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("bus answer without a request");
    a_unmapped_zero: assert property (
        $rose(avs_read) && avs_address == 6'h20
        |=> !avs_waitrequest && avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    // Port 0 is watched; the other ports share the same logic.
    a_msi_cause: assert property (
        msi_fwd[0] |-> ($past(hot_plug_irq[0], 2)
        || $past(bw_status[1:0], 2) != 2'h0))
        else $error("MSI without a source two cycles before");
    a_msi_pulse: assert property (msi_fwd[0] |=> !msi_fwd[0])
        else $error("MSI pulse longer than one cycle");
    a_msg_alternates: assert property (
        root_msg.valid |-> root_msg.assert_n_deassert != seen[root_msg.line])
        else $error("message repeats the line state");
    a_own_assert: assert property (
        $rose(up_own_intx[3]) && !seen[3] |-> ##[1:6] (root_msg.valid
        && root_msg.assert_n_deassert && root_msg.line == 2'h3))
        else $error("own line D rise gave no assert message");
    c_read: cover property (!avs_waitrequest && avs_read);
    c_msi: cover property (msi_fwd[0]);
    c_deassert: cover property (root_msg.valid && !root_msg.assert_n_deassert);
endmodule
bind spi_top spi_top_sva #(.NPORT(NPORT)) i_spi_top_sva (
    .ref_clk, .rst_b, .hot_plug_irq, .bw_status, .up_own_intx, .avs_address,
    .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .root_msg,
    .msi_fwd
);
`default_nettype wire

/* spi_root_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_root_model #(
    parameter int NPORT = 4
) (
    input wire logic                 ref_clk,
    input wire logic                 rst_b,
    input wire spi_pkg::spi_msg_type root_msg,
    input wire logic [NPORT-1:0]     msi_fwd,
    output var logic [3:0]           line_state,
    output var int                   msi_cnt
);
    // The root keeps one virtual wire per line from the message stream.
    // Every MSI is taken as aimed at the root, whatever port made it.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            line_state <= 4'h0;
            msi_cnt <= 0;
        end else begin
            msi_cnt <= msi_cnt + $countones(msi_fwd);
            if (root_msg.valid) begin
                line_state[root_msg.line] <= root_msg.assert_n_deassert;
            end
        end
    end
endmodule
`default_nettype wire

/* tb_spi_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_spi_top;
    localparam int NPORT = 4;
    logic                 ref_clk;
    logic                 rst_b = 1'b0;
    logic [NPORT-1:0]     hot_plug_irq = 4'h0;
    logic [NPORT*2-1:0]   bw_status = 8'h00;
    logic [NPORT*4-1:0]   ext_intx = 16'h0000;
    logic [NPORT*2-1:0]   dev_num = 8'h00;
    logic [3:0]           up_own_intx = 4'h0;
    logic [5:0]           avs_address = 6'h00;
    logic                 avs_read = 1'b0;
    logic                 avs_write = 1'b0;
    logic [31:0]          avs_writedata = 32'h0000_0000;
    logic [3:0]           avs_byteenable = 4'h0;
    logic [31:0]          avs_readdata;
    logic                 avs_waitrequest;
    spi_pkg::spi_msg_type root_msg;
    logic [NPORT-1:0]     msi_fwd;
    logic                 irq;
    logic [3:0]           line_state;
    int                   msi_cnt;
    int                   err_total = 0;
    int                   n_tests = 0;
    int                   c0;
    spi_top #(.NPORT(NPORT)) i_spi_top (
        .ref_clk, .rst_b, .hot_plug_irq, .bw_status, .ext_intx, .dev_num,
        .up_own_intx, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .root_msg,
        .msi_fwd, .irq
    );
    spi_root_model #(.NPORT(NPORT)) i_spi_root_model (
        .ref_clk, .rst_b, .root_msg, .msi_fwd, .line_state, .msi_cnt
    );
    // Free running 10 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Bus cycles hold every signal until waitrequest is sampled low.
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= 4'hF;
        avs_write <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    task automatic rdc(input logic [5:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        chk(avs_readdata, e);
        avs_read <= 1'b0;
    endtask
    // Waits a bounded time for the next root message and checks it.
    task automatic wmsg(input logic a, input logic [1:0] l);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 30 && !hit; i++) begin
            @(posedge ref_clk);
            hit = (root_msg.valid === 1'b1);
        end
        chk({28'h0, hit, root_msg.assert_n_deassert, root_msg.line},
            {28'h0, 1'b1, a, l});
    endtask
    task automatic quiet(input int n);
        int v;
        v = 0;
        repeat (n) begin
            @(posedge ref_clk);
            if (root_msg.valid !== 1'b0) v++;
        end
        chk(32'(v), 32'h0000_0000);
    endtask
    task automatic chk_irq(input logic e);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, {31'h0, e});
    endtask
    task tally_and_finish();
        if (err_total == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // A hang is cut short well beyond the expected run length.
    initial begin
        repeat (6000) @(posedge ref_clk);
        err_total++;
        tally_and_finish();
    end
    // Main sequence.
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rdc(spi_pkg::OFS_DL_UP, 32'h0000_0000);
        wr(6'h24, 32'hFFFF_FFFF);
        rdc(6'h24, 32'h0000_0000);
        rdc(6'h20, 32'h0000_0000);
        wr(spi_pkg::OFS_DL_UP, 32'h0000_000F);
        wr(spi_pkg::OFS_MSI_EN, 32'h0000_0000);
        wr(spi_pkg::OFS_LEG_DIS, 32'h0000_0000);
        wr(spi_pkg::OFS_BW_EN, 32'h0000_0000);
        wr(spi_pkg::OFS_IRQ_MASK, 32'h0000_0007);
        hot_plug_irq[0] <= 1'b1;
        wmsg(1'b1, 2'h0);
        rdc(spi_pkg::OFS_UP_STATE, 32'h0000_0001);
        chk({28'h0, line_state}, 32'h0000_0001);
        hot_plug_irq[0] <= 1'b0;
        wmsg(1'b0, 2'h0);
        chk_irq(1'b1);
        wr(spi_pkg::OFS_IRQ_STS, 32'h0000_0003);
        chk_irq(1'b0);
        for (int n = 0; n < 4; n++) begin
            for (int k = 0; k < 4; k++) begin
                dev_num[3:2] <= 2'(n);
                ext_intx[4+k] <= 1'b1;
                wmsg(1'b1, 2'((k + n) % 4));
                ext_intx[4+k] <= 1'b0;
                wmsg(1'b0, 2'((k + n) % 4));
            end
        end
        wr(spi_pkg::OFS_LEG_DIS, 32'h0000_0001);
        hot_plug_irq[0] <= 1'b1;
        quiet(10);
        hot_plug_irq[0] <= 1'b0;
        quiet(10);
        wr(spi_pkg::OFS_MSI_EN, 32'h0000_0001);
        for (int i = 1; i >= 0; i--) begin
            wr(spi_pkg::OFS_LEG_DIS, 32'(i));
            c0 = msi_cnt;
            hot_plug_irq[0] <= 1'b1;
            quiet(10);
            chk(32'(msi_cnt - c0), 32'h0000_0001);
            hot_plug_irq[0] <= 1'b0;
            quiet(10);
        end
        chk_irq(1'b1);
        wr(spi_pkg::OFS_IRQ_MASK, 32'h0000_0000);
        chk_irq(1'b0);
        wr(spi_pkg::OFS_IRQ_MASK, 32'h0000_0004);
        chk_irq(1'b1);
        wr(spi_pkg::OFS_IRQ_STS, 32'h0000_0004);
        chk_irq(1'b0);
        rdc(spi_pkg::OFS_IRQ_STS, 32'h0000_0000);
        wr(spi_pkg::OFS_BW_EN, 32'h0000_0002);
        c0 = msi_cnt;
        bw_status[0] <= 1'b1;
        quiet(8);
        chk(32'(msi_cnt - c0), 32'h0000_0000);
        bw_status[1] <= 1'b1;
        quiet(8);
        chk(32'(msi_cnt - c0), 32'h0000_0001);
        bw_status <= 8'h00;
        rdc(spi_pkg::OFS_MSI_CNT, 32'h0000_0003);
        wr(spi_pkg::OFS_MSI_EN, 32'h0000_0000);
        ext_intx[8] <= 1'b1;
        wmsg(1'b1, 2'h0);
        wr(spi_pkg::OFS_DL_UP, 32'h0000_000B);
        wmsg(1'b0, 2'h0);
        ext_intx[8] <= 1'b0;
        dev_num[3:2] <= 2'h0;
        up_own_intx <= 4'h8;
        wmsg(1'b1, 2'h3);
        ext_intx[7] <= 1'b1;
        quiet(8);
        up_own_intx <= 4'h0;
        quiet(8);
        ext_intx[7] <= 1'b0;
        wmsg(1'b0, 2'h3);
        tally_and_finish();
    end
endmodule
`default_nettype wire
